/* File: hdl/fdst_core.sv */
/*
 * Sector data-transfer engine (read, read deleted, read track, write) and
 * its byte FIFO. Assumes a data separator on I_CLK that reports ID fields,
 * data marks, byte ticks and CRC verdicts; index and TC come from pins.
 */
// Summary of operation
// - Execution starts only after the ninth command byte is taken.
// - Load head, settle, match ID, then read the data field into FIFO.
// - After each sector the record number steps by one and continues; a control-mark sector not skipped ends the command with R unchanged.
// - TC or FIFO overrun stops delivery; sector finishes, CRC checked, end.
// - Sector length is 128 bytes shifted left by the size code.
// - Size zero with short length below 128 moves only that many bytes.
// - Two-side flag continues from side 0 onto side 1 of the cylinder.
// - Head stays loaded for the unload interval; a new command skips settling.
// - Two index pulses without the sector give code 01 and sector absent.
// - ID or data CRC error gives CRC fault, ID CRC flag if ID on reads, code 01 except read track.
// - Read data: deleted mark sets control mark; ends or is skipped by flag.
// - Read deleted data swaps the roles of the two marks.
// - Read track starts after index, reads all fields, CRC errors don't stop.
// - Read track flags sector absent when an ID differs from the command.
// - Read track without any ID by the second index after the arming one gives code 01, missing address.
// - Result record is R+1, or 01 with cylinder or head advanced at final sector.
// - Write takes FIFO bytes into the field, appends CRC, steps record.
// - TC or FIFO underrun while writing pads the field with zeros.
// - Write with bad ID CRC gives code 01 and CRC fault, then ends.
// - Optional implied seek shows drive busy and reports failure in results.
`timescale 1ns/1ps
`default_nettype none
`include "fdst_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Byte FIFO, flag outputs registered
module fdst_fifo #(parameter int W = 8, parameter int D = 8) (
    input wire logic clk,              // Clock
    input wire logic rst_n,            // Async reset
    input wire logic flush,            // Empty the buffer
    input wire logic in_valid,         // Write strobe
    input wire logic [W-1:0] in_data,  // Write data
    output logic in_ready,             // Room left
    output logic out_valid,            // Data present
    output logic [W-1:0] out_data,     // Head word
    input wire logic out_ready         // Pop strobe
);
    localparam int AW = (D > 2) ? $clog2(D) : 1;
    if (D < 2) $error("fdst_fifo depth below 2");
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_data = mem_q[rp_q];
    // Pointers and registered flags, so full never lies to the source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else if (flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
            if (pop) rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_d;
            in_ready <= cnt_d != (AW + 1)'(D);
            out_valid <= cnt_d != '0;
        end
    end
    // Storage
    always_ff @(posedge clk) begin
        if (push) mem_q[wp_q] <= in_data;
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module fdst_core import fdst_pkg::*; #(parameter int FIFO_DEPTH = 8) (
    input wire logic I_CLK,              // 125 MHz clock
    input wire logic I_RESETN,           // Async reset, low
    input wire logic i_CMD_VALID,        // Command byte strobe
    input wire logic [7:0] i_CMD_BYTE,   // Command byte
    output logic o_CMD_READY,            // Command phase open
    input wire logic i_DIN_VALID,        // Host write byte valid
    input wire logic [7:0] i_DIN_BYTE,   // Host write byte
    output logic o_DIN_READY,            // Write FIFO room
    output logic o_DOUT_VALID,           // Read byte for host
    output logic [7:0] o_DOUT_BYTE,      // Read byte
    input wire logic i_DOUT_READY,       // Host takes read byte
    input wire logic i_TC,               // transfer_count_end pin
    output logic o_RES_VALID,            // Result byte valid
    output logic [7:0] o_RES_BYTE,       // Result byte
    input wire logic i_RES_ACK,          // Host took result byte
    input wire logic [15:0] i_SETTLE_CYC,  // Head settle, cycles
    input wire logic [15:0] i_UNLOAD_CYC,  // Head unload, cycles
    input wire logic i_SEEK_EN,          // Implied seek enabled
    output logic o_DRIVE_BUSY,           // Seek request / busy
    output logic [7:0] o_SEEK_CYL,       // Seek target
    input wire logic i_SEEK_DONE,        // Seek finished pulse
    input wire logic i_SEEK_FAIL,        // With done: failed
    output logic o_HEAD_LOAD,            // Head loaded
    input wire logic i_INDEX_PULSE_INPUT_N,  // Index pin, low
    input wire logic i_ID_VALID,         // ID field read pulse
    input wire logic [7:0] i_ID_C,       // ID cylinder
    input wire logic [7:0] i_ID_H,       // ID head
    input wire logic [7:0] i_ID_R,       // ID record
    input wire logic [7:0] i_ID_N,       // ID size
    input wire logic i_ID_CRC_OK,        // ID CRC good
    input wire logic i_DAM_VALID,        // Data mark found pulse
    input wire logic i_DAM_DELETED,      // Mark is deleted
    input wire logic i_BYTE_TICK,        // One field byte time
    input wire logic [7:0] i_RD_BYTE,    // Disk byte on tick
    input wire logic i_DCRC_VALID,       // Data CRC verdict pulse
    input wire logic i_DCRC_OK,          // Data CRC good
    output logic o_WR_GATE,              // Writing a field
    output logic [7:0] o_WR_BYTE,        // Byte to write
    output logic o_WR_CRC                // Append CRC pulse
);
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH below 2");
    fdst_state_t state_q;
    fdst_op_t op_q;
    logic [3:0] cnt_q;
    logic mt_q, sk_q, head_q, stop_q, seen_q, go_q, noinc_q, idxn_q;
    logic [2:0] sel_q, res_i_q;
    logic [7:0] c_q, h_q, r_q, n_q, eot_q, dtl_q, st1_q, st2_q, trk_q;
    logic [1:0] ic_q;
    logic [14:0] bcnt_q, seclen, xlen;
    logic [15:0] tmr_q;
    logic idx_m_q, idx_s_q, idx_d_q, tc_m_q, tc_s_q;
    logic idx_ev, id_match, odd, sending, rd, take_last, done, fin;
    logic rf_push, rf_rdy, wf_vld, wf_pop, settled;
    logic [7:0] wf_data;
    logic [4:0] opc;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; logic reads the second stage, and the third too for the index edge
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            idx_m_q <= 1'b1;
            idx_s_q <= 1'b1;
            idx_d_q <= 1'b1;
            tc_m_q <= 1'b0;
            tc_s_q <= 1'b0;
        end else begin
            idx_m_q <= i_INDEX_PULSE_INPUT_N;
            idx_s_q <= idx_m_q;
            idx_d_q <= idx_s_q;
            tc_m_q <= i_TC;
            tc_s_q <= tc_m_q;
        end
    end

    // Decodes
    assign idx_ev = idx_d_q && !idx_s_q;
    assign opc = i_CMD_BYTE[4:0];
    assign seclen = `FDST_SEC_BASE << n_q[2:0];
    assign xlen = (n_q == 8'h00 && dtl_q < `FDST_SHORT_MAX) ? {7'h00, dtl_q} : seclen;
    assign id_match = i_ID_C == c_q && i_ID_H == h_q && i_ID_R == r_q && i_ID_N == n_q;
    assign odd = i_DAM_DELETED ^ (op_q == OP_RDEL);
    assign sending = bcnt_q < xlen && !stop_q;
    assign rd = op_q != OP_WR;
    assign take_last = state_q == S_CMD && i_CMD_VALID && cnt_q == `FDST_CMD_LAST;
    assign settled = head_q || tmr_q >= i_SETTLE_CYC;
    assign rf_push = state_q == S_XFER && rd && i_BYTE_TICK && sending && rf_rdy;
    assign wf_pop = state_q == S_XFER && !rd && i_BYTE_TICK && sending && wf_vld;
    // Sector finished: good data CRC on reads (any verdict on read track), CRC slot on writes, or a skip
    assign done = (state_q == S_CRC && (rd ? i_DCRC_VALID && (i_DCRC_OK || op_q == OP_RTRK) : 1'b1))
        || (state_q == S_MARK && i_DAM_VALID && op_q != OP_RTRK && odd && sk_q);
    assign fin = stop_q || noinc_q || (op_q == OP_RTRK ? trk_q + 8'h01 == eot_q
        : r_q == eot_q && !(mt_q && !h_q[0]));

    ////////////////////////////////////////////////////////////////////////////
    // Command capture and sequencing
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_q <= S_CMD;
            cnt_q <= 4'h0;
            op_q <= OP_RD;
            {mt_q, sk_q, sel_q, c_q, h_q, r_q, n_q, eot_q, dtl_q} <= '0;
            {stop_q, seen_q, go_q, noinc_q, idxn_q} <= '0;
            trk_q <= 8'h00;
            res_i_q <= 3'h0;
            bcnt_q <= 15'h0000;
        end else begin
            if (tc_s_q || (state_q == S_XFER && i_BYTE_TICK && sending && (rd ? !rf_rdy : !wf_vld)))
                stop_q <= 1'b1;
            unique case (state_q)
                S_CMD: if (i_CMD_VALID) begin
                    cnt_q <= cnt_q + 4'h1;
                    unique case (cnt_q)
                        4'h0: begin
                            mt_q <= i_CMD_BYTE[`FDST_B_MT];
                            sk_q <= i_CMD_BYTE[`FDST_B_SK];
                            if (opc == `FDST_OP_RDATA) op_q <= OP_RD;
                            else if (opc == `FDST_OP_RDEL) op_q <= OP_RDEL;
                            else if (opc == `FDST_OP_RTRK) op_q <= OP_RTRK;
                            else if (opc == `FDST_OP_WDATA) op_q <= OP_WR;
                            else cnt_q <= 4'h0;
                        end
                        4'h1: sel_q <= i_CMD_BYTE[2:0];
                        4'h2: c_q <= i_CMD_BYTE;
                        4'h3: h_q <= i_CMD_BYTE;
                        4'h4: r_q <= i_CMD_BYTE;
                        4'h5: n_q <= i_CMD_BYTE;
                        4'h6: eot_q <= i_CMD_BYTE;
                        4'h7: ;
                        default: begin
                            dtl_q <= i_CMD_BYTE;
                            cnt_q <= 4'h0;
                            {stop_q, seen_q, go_q, noinc_q, idxn_q} <= '0;
                            trk_q <= 8'h00;
                            state_q <= i_SEEK_EN ? S_SEEK : S_SETTLE;
                        end
                    endcase
                end
                S_SEEK: if (i_SEEK_DONE) state_q <= i_SEEK_FAIL ? S_RESULT : S_SETTLE;
                S_SETTLE: if (settled) state_q <= S_SEARCH;
                S_SEARCH: begin
                    if (op_q == OP_RTRK && !go_q) begin
                        if (idx_ev) go_q <= 1'b1;
                    end else if (idx_ev && idxn_q) begin
                        state_q <= S_RESULT;
                    end else if (i_ID_VALID) begin
                        seen_q <= 1'b1;
                        if (!i_ID_CRC_OK && op_q != OP_RTRK) state_q <= S_RESULT;
                        else if (op_q == OP_RTRK || id_match) state_q <= rd ? S_MARK : S_XFER;
                    end else if (idx_ev) begin
                        idxn_q <= 1'b1;
                    end
                    bcnt_q <= 15'h0000;
                end
                S_MARK: if (i_DAM_VALID && !done) begin
                    state_q <= S_XFER;
                    if (op_q != OP_RTRK && odd) noinc_q <= 1'b1;
                end
                S_XFER: if (i_BYTE_TICK) begin
                    bcnt_q <= bcnt_q + 15'h0001;
                    if (bcnt_q == seclen - 15'h0001) state_q <= S_CRC;
                end
                S_CRC: if (rd && i_DCRC_VALID && !done) state_q <= S_RESULT;
                S_RESULT: if (o_RES_VALID && i_RES_ACK) begin
                    res_i_q <= res_i_q + 3'h1;
                    if (res_i_q == `FDST_RES_LAST) state_q <= S_CMD;
                end
            endcase
            // Next sector address and the result-phase ID
            if (done) begin
                idxn_q <= 1'b0;
                trk_q <= trk_q + 8'h01;
                state_q <= fin ? S_RESULT : S_SEARCH;
                if (!noinc_q) begin
                    if (r_q == eot_q) begin
                        r_q <= `FDST_REC_FIRST;
                        if (mt_q) h_q <= {h_q[7:1], ~h_q[0]};
                        if (!(mt_q && !h_q[0])) c_q <= c_q + 8'h01;
                    end else begin
                        r_q <= r_q + 8'h01;
                    end
                end
            end
            if (state_q != S_RESULT && state_q != S_CMD) res_i_q <= 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status registers: flags set during execution, cleared as the ninth command byte is taken
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ic_q <= `FDST_IC_OK;
            st1_q <= 8'h00;
            st2_q <= 8'h00;
        end else if (take_last) begin
            ic_q <= `FDST_IC_OK;
            st1_q <= 8'h00;
            st2_q <= 8'h00;
        end else begin
            if (state_q == S_SEEK && i_SEEK_DONE && i_SEEK_FAIL) ic_q <= `FDST_IC_ABN;
            if (state_q == S_SEARCH && idx_ev && idxn_q && (go_q || op_q != OP_RTRK)) begin
                ic_q <= `FDST_IC_ABN;
                if (op_q == OP_RTRK && !seen_q) st1_q[`FDST_ST1_MA] <= 1'b1;
                else if (op_q != OP_RTRK) st1_q[`FDST_ST1_ND] <= 1'b1;
            end
            if (state_q == S_SEARCH && i_ID_VALID && (op_q != OP_RTRK || go_q)) begin
                if (!i_ID_CRC_OK) begin
                    st1_q[`FDST_ST1_DE] <= 1'b1;
                    if (rd) st2_q[`FDST_ST2_DD] <= 1'b1;
                    if (op_q != OP_RTRK) ic_q <= `FDST_IC_ABN;
                end
                if (op_q == OP_RTRK && !id_match) st1_q[`FDST_ST1_ND] <= 1'b1;
            end
            if (state_q == S_MARK && i_DAM_VALID && op_q != OP_RTRK && odd) st2_q[`FDST_ST2_CM] <= 1'b1;
            if (state_q == S_CRC && rd && i_DCRC_VALID && !i_DCRC_OK) begin
                st1_q[`FDST_ST1_DE] <= 1'b1;
                if (op_q != OP_RTRK) ic_q <= `FDST_IC_ABN;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared timer: settle count while loading, unload count while idle
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tmr_q <= 16'h0000;
            head_q <= 1'b0;
        end else begin
            if ((state_q == S_SETTLE && !head_q) || ((state_q == S_CMD || state_q == S_RESULT) && head_q))
                tmr_q <= tmr_q + 16'h0001;
            else
                tmr_q <= 16'h0000;
            if (state_q == S_SETTLE && settled) head_q <= 1'b1;
            else if ((state_q == S_CMD || state_q == S_RESULT) && head_q && tmr_q >= i_UNLOAD_CYC) begin
                head_q <= 1'b0;
                tmr_q <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs; result bytes are muxed one cycle ahead
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            {o_CMD_READY, o_RES_VALID, o_DRIVE_BUSY, o_HEAD_LOAD, o_WR_GATE, o_WR_CRC} <= '0;
            {o_RES_BYTE, o_SEEK_CYL, o_WR_BYTE} <= '0;
        end else begin
            o_CMD_READY <= state_q == S_CMD;
            o_RES_VALID <= state_q == S_RESULT && !(o_RES_VALID && i_RES_ACK);
            unique case (res_i_q)
                3'h0: o_RES_BYTE <= {ic_q, 3'h0, sel_q};
                3'h1: o_RES_BYTE <= st1_q;
                3'h2: o_RES_BYTE <= st2_q;
                3'h3: o_RES_BYTE <= c_q;
                3'h4: o_RES_BYTE <= h_q;
                3'h5: o_RES_BYTE <= r_q;
                default: o_RES_BYTE <= n_q;
            endcase
            o_DRIVE_BUSY <= state_q == S_SEEK && !i_SEEK_DONE;
            o_SEEK_CYL <= c_q;
            o_HEAD_LOAD <= head_q || (state_q == S_SETTLE && settled);
            o_WR_GATE <= !rd && (state_q == S_XFER || state_q == S_SEARCH && i_ID_VALID && id_match && i_ID_CRC_OK);
            if (!rd && state_q == S_XFER && i_BYTE_TICK)
                o_WR_BYTE <= wf_pop ? wf_data : 8'h00;
            o_WR_CRC <= !rd && state_q == S_XFER && i_BYTE_TICK && bcnt_q == seclen - 15'h0001;
        end
    end

    // Read path: disk to host; write path: host to disk
    fdst_fifo #(.W(8), .D(FIFO_DEPTH)) u_rd_fifo (.clk(I_CLK), .rst_n(I_RESETN), .flush(take_last),
        .in_valid(rf_push), .in_data(i_RD_BYTE), .in_ready(rf_rdy), .out_valid(o_DOUT_VALID),
        .out_data(o_DOUT_BYTE), .out_ready(i_DOUT_READY));
    fdst_fifo #(.W(8), .D(FIFO_DEPTH)) u_wr_fifo (.clk(I_CLK), .rst_n(I_RESETN), .flush(1'b0),
        .in_valid(i_DIN_VALID), .in_data(i_DIN_BYTE), .in_ready(o_DIN_READY), .out_valid(wf_vld),
        .out_data(wf_data), .out_ready(wf_pop));

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    property p_nine; state_q == S_CMD ##1 state_q != S_CMD |-> $past(cnt_q) == `FDST_CMD_LAST; endproperty
    a_nine: assert property (p_nine) else $error("execution began early");
    property p_head; state_q == S_SEARCH |-> o_HEAD_LOAD; endproperty
    a_head: assert property (p_head) else $error("search with head unloaded");
    property p_short; rf_push && n_q == 8'h00 && dtl_q < `FDST_SHORT_MAX |-> bcnt_q < {7'h00, dtl_q}; endproperty
    a_short: assert property (p_short) else $error("read byte beyond length");
    property p_stop; tc_s_q |=> !rf_push; endproperty
    a_stop: assert property (p_stop) else $error("data after stop");
    property p_pad; !rd && state_q == S_XFER && i_BYTE_TICK && stop_q |=> o_WR_BYTE == 8'h00; endproperty
    a_pad: assert property (p_pad) else $error("write not padded");
    property p_dd; $rose(st2_q[`FDST_ST2_DD]) && op_q != OP_RTRK |-> st1_q[`FDST_ST1_DE] && ic_q == `FDST_IC_ABN;
    endproperty
    a_dd: assert property (p_dd) else $error("ID CRC flags inconsistent");
    property p_nd; $rose(st1_q[`FDST_ST1_ND]) && op_q != OP_RTRK |-> ic_q == `FDST_IC_ABN ##0 state_q == S_RESULT;
    endproperty
    a_nd: assert property (p_nd) else $error("sector absent without end");
    property p_unld; $fell(o_HEAD_LOAD) |-> $past(state_q, 2) inside {S_CMD, S_RESULT}; endproperty
    a_unld: assert property (p_unld) else $error("head dropped while busy");
    property p_rec; done && !noinc_q && r_q != eot_q |=> r_q == $past(r_q) + 8'h01; endproperty
    a_rec: assert property (p_rec) else $error("record not stepped");
    c_end: cover property (state_q == S_RESULT && ic_q == `FDST_IC_OK);
    c_cm: cover property ($rose(st2_q[`FDST_ST2_CM]));
    c_wcrc: cover property (o_WR_CRC);
endmodule
`default_nettype wire

/* File: pkg/fdst_defs.svh */
/*
 * Constants of the sector transfer engine: command layout, status bits,
 * sizes. Assumes inclusion by bare name from design files.
 */
`ifndef FDST_DEFS_SVH
`define FDST_DEFS_SVH
`define FDST_CMD_LAST 4'h8
`define FDST_OP_RDATA 5'h06
`define FDST_OP_RDEL 5'h0c
`define FDST_OP_RTRK 5'h02
`define FDST_OP_WDATA 5'h05
`define FDST_B_MT 7
`define FDST_B_SK 5
`define FDST_ST1_DE 5
`define FDST_ST1_ND 2
`define FDST_ST1_MA 0
`define FDST_ST2_CM 6
`define FDST_ST2_DD 5
`define FDST_IC_OK 2'h0
`define FDST_IC_ABN 2'h1
`define FDST_SEC_BASE 15'h0080
`define FDST_SHORT_MAX 8'h80
`define FDST_RES_LAST 3'h6
`define FDST_REC_FIRST 8'h01
`endif

/* File: pkg/fdst_pkg.sv */
/*
 * Types of the sector transfer engine. Assumes nothing.
 */
`default_nettype none
package fdst_pkg;
    typedef enum logic [2:0] {S_CMD, S_SEEK, S_SETTLE, S_SEARCH, S_MARK, S_XFER, S_CRC, S_RESULT} fdst_state_t;
    typedef enum logic [1:0] {OP_RD, OP_RDEL, OP_RTRK, OP_WR} fdst_op_t;
endpackage
`default_nettype wire

/* File: sim/fdst_drive.sv */
/* Drive and data-separator model: index, ID fields, marks, read bytes.
   Assumes its tasks are called from a process woken on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module fdst_drive (
    input wire logic i_clk,     // Clock
    output logic o_index_n,     // Index pin
    output logic o_id_v,        // ID pulse
    output logic [31:0] o_id,   // C,H,R,N
    output logic o_id_ok,       // ID CRC good
    output logic o_dam_v,       // Mark pulse
    output logic o_dam_del,     // Deleted mark
    output logic o_tick,        // Byte tick
    output logic [7:0] o_byte,  // Disk byte
    output logic o_dcrc_v,      // Data CRC pulse
    output logic o_dcrc_ok      // Data CRC good
);
    // Idle levels at time zero
    initial begin
        {o_id_v, o_id, o_id_ok, o_dam_v, o_dam_del, o_tick, o_dcrc_v, o_dcrc_ok} = '0;
        o_index_n = 1'b1;
        o_byte = 8'h5a;
    end
    // Long low time so the synchroniser cannot miss it
    task automatic pulse_index();
        o_index_n = 1'b0;
        repeat (4) @(negedge i_clk);
        o_index_n = 1'b1;
        repeat (30) @(negedge i_clk);
    endtask
    // ID fields are dropped to their inverse once the pulse is over
    task automatic send_id(input logic [31:0] chrn, input logic ok);
        o_id = chrn;
        o_id_ok = ok;
        o_id_v = 1'b1;
        @(negedge i_clk);
        o_id_v = 1'b0;
        o_id = ~chrn;
        repeat (8) @(negedge i_clk);
    endtask
    // Byte lane flips between ticks so a stale byte is never taken twice
    task automatic send_data(input logic del, input int len, input logic ok);
        o_dam_v = 1'b1;
        o_dam_del = del;
        @(negedge i_clk);
        o_dam_v = 1'b0;
        for (int i = 0; i < len; i++) begin
            o_tick = 1'b1;
            o_byte = 8'h40 + i[7:0];
            @(negedge i_clk);
            o_tick = 1'b0;
            o_byte = ~o_byte;
            repeat (3) @(negedge i_clk);
        end
        o_dcrc_v = 1'b1;
        o_dcrc_ok = ok;
        @(negedge i_clk);
        o_dcrc_v = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
/* Bench for the sector read commands, host side by hand, drive by model.
   Assumes fdst_core and fdst_drive are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst_n, cmd_v, cmd_rdy, dout_v, dout_rdy, res_v, res_ack;
    logic idx_n, id_v, id_ok, dam_v, dam_del, tick, dcrc_v, dcrc_ok;
    logic [7:0] cmd_b, dout_b, res_b, rbyte;
    logic [31:0] id;
    logic tc, sk_en, sk_done, sk_fail, busy;
    logic [7:0] seek_cyl;
    int fails = 0, cmp_count = 0, nb = 0;
    fdst_drive drv (.i_clk(clk), .o_index_n(idx_n), .o_id_v(id_v), .o_id(id), .o_id_ok(id_ok), .o_dam_v(dam_v),
        .o_dam_del(dam_del), .o_tick(tick), .o_byte(rbyte), .o_dcrc_v(dcrc_v), .o_dcrc_ok(dcrc_ok));
    fdst_core dut (.I_CLK(clk), .I_RESETN(rst_n), .i_CMD_VALID(cmd_v), .i_CMD_BYTE(cmd_b), .o_CMD_READY(cmd_rdy),
        .i_DIN_VALID(1'b0), .i_DIN_BYTE(8'h00), .o_DIN_READY(), .o_DOUT_VALID(dout_v), .o_DOUT_BYTE(dout_b),
        .i_DOUT_READY(dout_rdy), .i_TC(tc), .o_RES_VALID(res_v), .o_RES_BYTE(res_b), .i_RES_ACK(res_ack),
        .i_SETTLE_CYC(16'h0008), .i_UNLOAD_CYC(16'h0200), .i_SEEK_EN(sk_en), .o_DRIVE_BUSY(busy),
        .o_SEEK_CYL(seek_cyl), .i_SEEK_DONE(sk_done), .i_SEEK_FAIL(sk_fail), .o_HEAD_LOAD(),
        .i_INDEX_PULSE_INPUT_N(idx_n), .i_ID_VALID(id_v),
        .i_ID_C(id[31:24]), .i_ID_H(id[23:16]), .i_ID_R(id[15:8]), .i_ID_N(id[7:0]), .i_ID_CRC_OK(id_ok),
        .i_DAM_VALID(dam_v), .i_DAM_DELETED(dam_del), .i_BYTE_TICK(tick), .i_RD_BYTE(rbyte),
        .i_DCRC_VALID(dcrc_v), .i_DCRC_OK(dcrc_ok), .o_WR_GATE(), .o_WR_BYTE(), .o_WR_CRC());
    // 8 ns clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Host stalls every other cycle; each taken byte must follow the disk order
    always @(negedge clk) dout_rdy <= ~dout_rdy;
    always @(posedge clk) if (dout_v && dout_rdy) begin
        chk(dout_b, 8'h40 + nb[7:0]);
        nb++;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Nine bytes: C=03 H=00 R=01 N=00, final sector 01 unless given; then settle time
    task automatic cmd(input logic [7:0] op, input logic [7:0] short_length, input logic [7:0] final_sector_number = 8'h01);
        logic [7:0] b [9];
        b = '{op, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, final_sector_number, 8'h1b, short_length};
        while (cmd_rdy !== 1'b1) @(negedge clk);
        for (int i = 0; i < 9; i++) begin
            cmd_v = 1'b1;
            cmd_b = b[i];
            @(negedge clk);
        end
        cmd_v = 1'b0;
        nb = 0;
        repeat (40) @(negedge clk);
    endtask
    // Seven result bytes, the first n compared
    task automatic res(input logic [7:0] s0, s1, s2, c, input int n);
        logic [7:0] e [7];
        e = '{s0, s1, s2, c, 8'h00, 8'h01, 8'h00};
        for (int i = 0; i < 7; i++) begin
            while (res_v !== 1'b1) @(negedge clk);
            if (i < n) chk(res_b, e[i]);
            res_ack = 1'b1;
            @(negedge clk);
            res_ack = 1'b0;
            @(negedge clk);
        end
    endtask
    // Main sequence
    initial begin
        {rst_n, cmd_v, cmd_b, res_ack, dout_rdy} = '0;
        {tc, sk_en, sk_done, sk_fail} = '0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        cmd(8'h06, 8'h04);
        drv.send_id(32'h0300_0100, 1'b1);
        drv.send_data(1'b0, 128, 1'b1);
        res(8'h00, 8'h00, 8'h00, 8'h04, 7);
        chk(nb[7:0], 8'h04);
        cmd(8'h0c, 8'h04);
        drv.send_id(32'h0300_0100, 1'b1);
        drv.send_data(1'b0, 128, 1'b1);
        res(8'h00, 8'h00, 8'h40, 8'h03, 7);
        cmd(8'h06, 8'hff);
        drv.send_id(32'h0300_0100, 1'b0);
        res(8'h40, 8'h20, 8'h20, 8'h03, 7);
        cmd(8'h06, 8'hff);
        drv.send_id(32'h0300_0500, 1'b1);
        drv.pulse_index();
        drv.pulse_index();
        res(8'h40, 8'h04, 8'h00, 8'h03, 7);
        // Two sectors of two bytes; record steps 01 to 02, then wraps
        cmd(8'h06, 8'h02, 8'h02);
        drv.send_id(32'h0300_0100, 1'b1);
        drv.send_data(1'b0, 128, 1'b1);
        chk(nb[7:0], 8'h02);
        nb = 0;
        drv.send_id(32'h0300_0200, 1'b1);
        drv.send_data(1'b0, 128, 1'b1);
        res(8'h00, 8'h00, 8'h00, 8'h04, 7);
        chk(nb[7:0], 8'h02);
        // Count end before the field: nothing delivered, sector still closes
        cmd(8'h06, 8'hff);
        tc = 1'b1;
        drv.send_id(32'h0300_0100, 1'b1);
        drv.send_data(1'b0, 128, 1'b1);
        res(8'h00, 8'h00, 8'h00, 8'h04, 7);
        tc = 1'b0;
        chk(nb[7:0], 8'h00);
        // Implied seek that fails
        sk_en = 1'b1;
        cmd(8'h06, 8'hff);
        sk_en = 1'b0;
        chk({7'h00, busy}, 8'h01);
        chk(seek_cyl, 8'h03);
        {sk_done, sk_fail} = 2'b11;
        @(negedge clk);
        {sk_done, sk_fail} = 2'b00;
        res(8'h40, 8'h00, 8'h00, 8'h03, 7);
        // Read track with no ID at all: arming index, then two more
        cmd(8'h02, 8'hff);
        repeat (3) drv.pulse_index();
        res(8'h40, 8'h01, 8'h00, 8'h03, 7);
        end_sim();
    end
    // Watchdog well beyond the expected run
    initial begin
        #400000;
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
